/* design/periodic_wakeup_and_system_options.sv */
// periodic wakeup timer, system options two, identification registers
// assumes ext_clk_in and osc ticks synchronous to pclk, apb master
//
// Behaviour
// - timer1 ext select bit 3: 0 ext clock pin, 1 timer two overflow
// - converter trigger bit 2: 0 periodic overflow, 1 timer one overflow
// - channel one pin bit 1: 0 port a bit 1, 1 port b bit 5
// - channel zero pin bit 0: 0 port a bit 0, 1 port b bit 4
// - identification registers are read-only, hard-wired
// - high id bits 7:4 give a 4-bit revision
// - 12-bit part number: top four in high 3:0, low eight in low
// - timeout flag bit 7 read-only, set when selected period reached
// - writing 1 to ack bit 6 clears flag; ack reads 0
// - clock select bit 5: 0 internal 1 kHz, 1 external clock
// - interrupt enable bit 4 allows periodic requests
// - delay field 2:0 rw; 000 stops and clears counter
// - internal periods 8,32,64,128,256,512 ms and 1.024 s
// - external periods 256 up to 32768 external cycles
// - pending bit clears with the flag and on reset
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module periodic_wakeup_and_system_options
	import wakeup_sys_pkg::*;
#(
	parameter int osc_div_cycles = osc_div,
	parameter logic [3:0] rev_code = rev_default,
	parameter logic [11:0] part_code = part_default
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clk_in,
	input wire logic ext_timer_clock_pin,
	input wire logic timer_two_ovf,
	input wire logic timer_one_ovf,
	input wire logic [1:0] timer_clock_source_field,
	input wire logic pwm_channel_one,
	input wire logic pwm_channel_zero,
	output logic timer_one_ext_clk,
	output logic converter_hw_trigger,
	output logic periodic_ovf_pulse,
	output logic periodic_irq_req,
	output logic port_a_bit_zero,
	output logic port_a_bit_one,
	output logic port_b_bit_four,
	output logic port_b_bit_five,
	output logic irq
);

	// ==========================================================
	// bus decode
	// ==========================================================
	// zero-wait slave; unmapped addresses answer pslverr
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire sel_opts = paddr == addr_opts_two;
	wire sel_idh = paddr == addr_id_high;
	wire sel_idl = paddr == addr_id_low;
	wire sel_ctl = paddr == addr_tmr_ctl;
	wire sel_stat = paddr == addr_irq_stat;
	wire sel_mask = paddr == addr_irq_mask;
	wire sel_pend = paddr == addr_pending;
	wire mapped = sel_opts | sel_idh | sel_idl | sel_ctl | sel_stat
		| sel_mask | sel_pend;
	// id and pending registers refuse writes
	wire ro_write = pwrite & (sel_idh | sel_idl | sel_pend);
	assign pready = 1'b1;
	assign pslverr = access & (~mapped | ro_write);

	logic [3:0] opts_r;
	logic flag_r;
	logic clk_sel_r;
	logic irq_en_r;
	logic [2:0] delay_r;
	logic stat_r;
	logic mask_r;
	logic [31:0] prdata_r;
	logic [15:0] div_r;
	logic [15:0] div_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic ext_d_r;
	logic ovf_r;

	// ==========================================================
	// period selection
	// ==========================================================
	logic [15:0] period;
	always_comb
	begin
		period = 16'h0;
		if (!clk_sel_r)
		begin
			case (delay_r)
				3'h1: period = 16'(per_ms_1);
				3'h2: period = 16'(per_ms_2);
				3'h3: period = 16'(per_ms_3);
				3'h4: period = 16'(per_ms_4);
				3'h5: period = 16'(per_ms_5);
				3'h6: period = 16'(per_ms_6);
				3'h7: period = 16'(per_ms_7);
				default: period = 16'h0;
			endcase
		end
		else
		begin
			case (delay_r)
				3'h1: period = 16'(per_ext_1);
				3'h2: period = 16'(per_ext_2);
				3'h3: period = 16'(per_ext_3);
				3'h4: period = 16'(per_ext_4);
				3'h5: period = 16'(per_ext_5);
				3'h6: period = 16'(per_ext_6);
				3'h7: period = 16'(per_ext_7);
				default: period = 16'h0;
			endcase
		end
	end
	// 16 bits hold the longest external period, 32768 ticks
	wire run = delay_r != delay_off;
	wire osc_tick = div_r == 16'(osc_div_cycles - 1);
	assign div_nxt = (osc_tick | ~run) ? 16'h0 : div_r + 16'h1;
	wire ext_tick = ext_clk_in & ~ext_d_r;
	// tick source follows the clock select
	wire tick = run & (clk_sel_r ? ext_tick : osc_tick);
	// hit on the period's last tick, so counts run 0 to period-1
	wire hit = tick & (cnt_r == period - 16'h1);
	assign cnt_nxt = ~run ? 16'h0 : hit ? 16'h0 : tick ? cnt_r + 16'h1
		: cnt_r;

	// ==========================================================
	// timer state
	// ==========================================================
	// counter holds cleared while the delay field is off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_r <= 16'h0;
			cnt_r <= 16'h0;
			ext_d_r <= 1'b0;
			ovf_r <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			ext_d_r <= ext_clk_in;
			ovf_r <= hit;
		end
	end

	// ==========================================================
	// registers
	// ==========================================================
	wire ack = wr & sel_ctl & pwdata[bit_ack];
	wire stat_clr = wr & sel_stat & pwdata[0];
	// set wins over clear for the flag and the sticky status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			opts_r <= 4'h0;
			flag_r <= 1'b0;
			clk_sel_r <= 1'b0;
			irq_en_r <= 1'b0;
			delay_r <= 3'h0;
			stat_r <= 1'b0;
			mask_r <= 1'b0;
		end
		else
		begin
			if (wr & sel_opts)
				opts_r <= pwdata[3:0];
			if (wr & sel_ctl)
			begin
				clk_sel_r <= pwdata[bit_clk_sel];
				irq_en_r <= pwdata[bit_irq_en];
				delay_r <= pwdata[2:0];
			end
			flag_r <= hit | (flag_r & ~ack);
			stat_r <= hit | (stat_r & ~stat_clr);
			if (wr & sel_mask)
				mask_r <= pwdata[0];
		end
	end

	// ==========================================================
	// read data
	// ==========================================================
	// ack bit always reads zero
	wire [7:0] ctl_rd = {flag_r, 1'b0, clk_sel_r, irq_en_r, 1'b0,
		delay_r};
	wire [7:0] idh_rd = {rev_code, part_code[11:8]};
	wire [7:0] idl_rd = part_code[7:0];
	wire [7:0] pend_rd = {7'h0, flag_r};
	wire [7:0] rd_byte = sel_opts ? {4'h0, opts_r} : sel_idh ? idh_rd
		: sel_idl ? idl_rd : sel_ctl ? ctl_rd : sel_stat ? {7'h0, stat_r}
		: sel_mask ? {7'h0, mask_r} : sel_pend ? pend_rd : 8'h0;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h0;
		else if (psel & ~penable & ~pwrite)
			prdata_r <= {24'h0, rd_byte};
	end
	assign prdata = prdata_r;

	// ==========================================================
	// routing
	// ==========================================================
	wire src_ext = timer_clock_source_field[1] == clk_src_ext_hi[1];
	// selected clock only reaches timer one in external mode
	assign timer_one_ext_clk = src_ext & (opts_r[bit_t1_ext]
		? timer_two_ovf : ext_timer_clock_pin);
	assign converter_hw_trigger = opts_r[bit_conv_trig] ? timer_one_ovf
		: ovf_r;
	assign port_a_bit_one = ~opts_r[bit_ch1_pin] & pwm_channel_one;
	assign port_b_bit_five = opts_r[bit_ch1_pin] & pwm_channel_one;
	assign port_a_bit_zero = ~opts_r[bit_ch0_pin] & pwm_channel_zero;
	assign port_b_bit_four = opts_r[bit_ch0_pin] & pwm_channel_zero;
	assign periodic_ovf_pulse = ovf_r;
	assign periodic_irq_req = flag_r & irq_en_r;
	assign irq = stat_r & mask_r;

	// ==========================================================
	// checks
	// ==========================================================
	property p_ack_clear;
		@(posedge pclk) disable iff (!presetn)
		(ack & ~hit) |=> !flag_r;
	endproperty
	a_ack_clear: assert property (p_ack_clear)
		else $error("ack did not clear flag");

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		hit |=> flag_r && ovf_r;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("timeout did not set flag");

	property p_pulse_one;
		@(posedge pclk) disable iff (!presetn)
		ovf_r |=> !ovf_r;
	endproperty
	a_pulse_one: assert property (p_pulse_one)
		else $error("overflow pulse longer than one cycle");

	property p_off_clear;
		@(posedge pclk) disable iff (!presetn)
		!run |=> cnt_r == 16'h0;
	endproperty
	a_off_clear: assert property (p_off_clear)
		else $error("counter not cleared when off");

	property p_irq_req;
		@(posedge pclk) disable iff (!presetn)
		periodic_irq_req == (flag_r && irq_en_r);
	endproperty
	a_irq_req: assert property (p_irq_req)
		else $error("irq request mismatch");

	property p_trig;
		@(posedge pclk) disable iff (!presetn)
		!opts_r[bit_conv_trig] |-> converter_hw_trigger == ovf_r;
	endproperty
	a_trig: assert property (p_trig)
		else $error("trigger routing wrong");

	property p_id_ro;
		@(posedge pclk) disable iff (!presetn)
		(access & sel_idh) |-> pslverr == pwrite;
	endproperty
	a_id_ro: assert property (p_id_ro)
		else $error("id write not refused");

	property p_pend;
		@(posedge pclk) disable iff (!presetn)
		(ack & ~hit) |=> pend_rd[bit_pend_periodic] == 1'b0;
	endproperty
	a_pend: assert property (p_pend)
		else $error("pending not cleared");

	property p_restart;
		@(posedge pclk) disable iff (!presetn)
		hit |=> cnt_r == 16'h0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("count did not restart after timeout");

	property p_count_up;
		@(posedge pclk) disable iff (!presetn)
		(tick & ~hit) |=> cnt_r == $past(cnt_r) + 16'h1;
	endproperty
	a_count_up: assert property (p_count_up)
		else $error("counter missed a tick");

	property p_flag_hold;
		@(posedge pclk) disable iff (!presetn)
		(flag_r & ~ack) |=> flag_r;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("flag lost without ack");

	property p_flag_quiet;
		@(posedge pclk) disable iff (!presetn)
		(!flag_r & !hit) |=> !flag_r;
	endproperty
	a_flag_quiet: assert property (p_flag_quiet)
		else $error("flag set without timeout");

	property p_ovf_quiet;
		@(posedge pclk) disable iff (!presetn)
		!hit |=> !ovf_r;
	endproperty
	a_ovf_quiet: assert property (p_ovf_quiet)
		else $error("overflow pulse without timeout");

	property p_stop_quiet;
		@(posedge pclk) disable iff (!presetn)
		!run |=> !ovf_r;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("overflow while stopped");

	property p_irq_block;
		@(posedge pclk) disable iff (!presetn)
		!irq_en_r |-> !periodic_irq_req;
	endproperty
	a_irq_block: assert property (p_irq_block)
		else $error("request while interrupt disabled");

	property p_pins_one;
		@(posedge pclk) disable iff (!presetn)
		!(port_a_bit_one && port_b_bit_five);
	endproperty
	a_pins_one: assert property (p_pins_one)
		else $error("channel one on both pins");

	property p_pins_zero;
		@(posedge pclk) disable iff (!presetn)
		!(port_a_bit_zero && port_b_bit_four);
	endproperty
	a_pins_zero: assert property (p_pins_zero)
		else $error("channel zero on both pins");

	property p_t1_gate;
		@(posedge pclk) disable iff (!presetn)
		(timer_clock_source_field[1] != clk_src_ext_hi[1])
			|-> !timer_one_ext_clk;
	endproperty
	a_t1_gate: assert property (p_t1_gate)
		else $error("timer one clock leaked in internal mode");

	property p_id_read;
		@(posedge pclk) disable iff (!presetn)
		(psel & ~penable & ~pwrite & sel_idl)
			|=> prdata == {24'h0, part_code[7:0]};
	endproperty
	a_id_read: assert property (p_id_read)
		else $error("low id read wrong");

	c_hit: cover property (@(posedge pclk) disable iff (!presetn) hit);
	c_ack: cover property (@(posedge pclk) disable iff (!presetn)
		flag_r ##1 !flag_r);
	c_ext: cover property (@(posedge pclk) disable iff (!presetn)
		hit && clk_sel_r);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn)
		periodic_irq_req ##1 !periodic_irq_req);
	c_off: cover property (@(posedge pclk) disable iff (!presetn)
		run ##1 !run);

endmodule

/* design/wakeup_sys_pkg.sv */
// constants for the periodic wakeup timer and system options block
// assumes a 32-bit apb slave with one register per aligned word
package wakeup_sys_pkg;
	// register byte addresses
	localparam logic [7:0] addr_opts_two = 8'h00;
	localparam logic [7:0] addr_id_high = 8'h04;
	localparam logic [7:0] addr_id_low = 8'h08;
	localparam logic [7:0] addr_tmr_ctl = 8'h0c;
	localparam logic [7:0] addr_irq_stat = 8'h10;
	localparam logic [7:0] addr_irq_mask = 8'h14;
	localparam logic [7:0] addr_pending = 8'h18;
	// field positions
	localparam int bit_t1_ext = 3;
	localparam int bit_conv_trig = 2;
	localparam int bit_ch1_pin = 1;
	localparam int bit_ch0_pin = 0;
	localparam int bit_flag = 7;
	localparam int bit_ack = 6;
	localparam int bit_clk_sel = 5;
	localparam int bit_irq_en = 4;
	localparam int bit_pend_periodic = 0;
	localparam logic [1:0] clk_src_ext_hi = 2'h2; // 10 and 11 are external
	localparam logic [2:0] delay_off = 3'h0;
	// identification, values arbitrary
	localparam logic [3:0] rev_default = 4'h1;
	localparam logic [11:0] part_default = 12'h123;
	// internal tick from 1 kHz, in pclk cycles at 40 MHz
	localparam int pclk_hz = 40000000;
	localparam int osc_hz = 1000;
	localparam int osc_div = pclk_hz / osc_hz;
	// internal periods in ms
	localparam int per_ms_1 = 8;
	localparam int per_ms_2 = 32;
	localparam int per_ms_3 = 64;
	localparam int per_ms_4 = 128;
	localparam int per_ms_5 = 256;
	localparam int per_ms_6 = 512;
	localparam int per_ms_7 = 1024;
	// external periods in external clock cycles
	localparam int per_ext_1 = 256;
	localparam int per_ext_2 = 1024;
	localparam int per_ext_3 = 2048;
	localparam int per_ext_4 = 4096;
	localparam int per_ext_5 = 8192;
	localparam int per_ext_6 = 16384;
	localparam int per_ext_7 = 32768;
endpackage

/* tb/test_periodic_wakeup_and_system_options.sv */
// self-checking bench for the periodic wakeup and system options block
// assumes a zero-wait apb slave and the oscillator tick cut to 4 pclk
`timescale 1ns/1ps
module test_periodic_wakeup_and_system_options;
	import wakeup_sys_pkg::*;
	localparam int div = 4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, ext_clk_in = 0, pin = 0, two = 0, one = 0;
	logic [1:0] src = 2'h0, ediv = 2'h0;
	logic ch1 = 0, ch0 = 0, ext_run = 0;
	logic t1, conv, ovf, req, pa0, pa1, pb4, pb5, irq;
	int n_fail = 0, compares = 0, cyc = 0;
	// ==========================================
	// clock, external timer clock, watchdog
	always #12.5 pclk = ~pclk;
	// external clock at a quarter of pclk, well under the sampling limit
	always @(posedge pclk)
	begin
		ediv <= ediv + 2'h1;
		ext_clk_in <= ext_run && ediv[1];
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			close_out();
		end
	end
	periodic_wakeup_and_system_options #(.osc_div_cycles(div))
	u_periodic_wakeup_and_system_options (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clk_in(ext_clk_in),
		.ext_timer_clock_pin(pin), .timer_two_ovf(two),
		.timer_one_ovf(one), .timer_clock_source_field(src),
		.pwm_channel_one(ch1), .pwm_channel_zero(ch0),
		.timer_one_ext_clk(t1), .converter_hw_trigger(conv),
		.periodic_ovf_pulse(ovf), .periodic_irq_req(req),
		.port_a_bit_zero(pa0), .port_a_bit_one(pa1),
		.port_b_bit_four(pb4), .port_b_bit_five(pb5), .irq(irq));
	// ==========================================
	// shared tasks
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic x);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk({31'h0, e}, {31'h0, x});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, 32'h0);
	endtask
	// counts falling edges up to and including the next pulse
	task automatic wait_pulse(input int bound, output int n);
		n = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (ovf !== 1'b1 && n < bound);
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs();
		rd(addr_opts_two, 32'h0);
		rd(addr_id_high, {24'h0, rev_default, part_default[11:8]});
		rd(addr_id_low, {24'h0, part_default[7:0]});
		wr(addr_id_high, 32'hff, 1'b1);
		wr(addr_id_low, 32'hff, 1'b1);
		rd(addr_id_low, {24'h0, part_default[7:0]});
		wr(addr_pending, 32'h1, 1'b1);
		wr(8'h1c, 32'h1, 1'b1);
		wr(addr_tmr_ctl, 32'hf5, 1'b0);
		rd(addr_tmr_ctl, 32'h35);
		wr(addr_tmr_ctl, 32'h0, 1'b0);
		$display("registers done");
	endtask
	task automatic t_route();
		logic [5:0] e;
		for (int v = 0; v < 16; v++)
		begin
			wr(addr_opts_two, 32'(v), 1'b0);
			for (int i = 0; i < 128; i++)
			begin
				@(posedge pclk);
				{pin, two, one, src, ch1, ch0} <= 7'(i);
				@(negedge pclk);
				e = {src[1] & (v[3] ? two : pin), v[2] & one, ~v[0] & ch0,
					~v[1] & ch1, v[0] & ch0, v[1] & ch1};
				chk({26'h0, t1, conv, pa0, pa1, pb4, pb5},
					{26'h0, e});
			end
		end
		wr(addr_opts_two, 32'h0, 1'b0);
		$display("routing done");
	endtask
	task automatic t_internal();
		int per [7] = '{per_ms_1, per_ms_2, per_ms_3, per_ms_4, per_ms_5,
			per_ms_6, per_ms_7};
		int n;
		for (int k = 1; k < 8; k++)
		begin
			wr(addr_tmr_ctl, 32'h10, 1'b0);
			wr(addr_tmr_ctl, 32'h10 | k, 1'b0);
			wait_pulse(6000, n);
			chk({31'h0, conv}, 32'h1);
			wait_pulse(6000, n);
			chk(32'(n), 32'(per[k - 1] * div));
			@(negedge pclk);
			chk({31'h0, ovf}, 32'h0);
		end
		rd(addr_tmr_ctl, 32'h97);
		rd(addr_pending, 32'h1);
		chk({30'h0, req, irq}, 32'h2);
		wr(addr_irq_mask, 32'h1, 1'b0);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(addr_irq_stat, 32'h1, 1'b0);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		wr(addr_tmr_ctl, 32'h07, 1'b0);
		@(negedge pclk);
		chk({31'h0, req}, 32'h0);
		wr(addr_tmr_ctl, 32'h47, 1'b0);
		rd(addr_tmr_ctl, 32'h07);
		rd(addr_pending, 32'h0);
		$display("internal source done");
	endtask
	// a stale count would bring the first pulse early after restart
	task automatic t_stop();
		int n;
		wr(addr_tmr_ctl, 32'h01, 1'b0);
		wait_pulse(100, n);
		repeat (20) @(negedge pclk);
		wr(addr_tmr_ctl, 32'h00, 1'b0);
		wait_pulse(300, n);
		chk({31'h0, ovf}, 32'h0);
		wr(addr_tmr_ctl, 32'h01, 1'b0);
		wait_pulse(100, n);
		chk({31'h0, n >= 26 && n <= 38}, 32'h1);
		$display("stop done");
	endtask
	task automatic t_external();
		int n;
		wr(addr_tmr_ctl, 32'h31, 1'b0);
		wait_pulse(400, n);
		chk({31'h0, ovf}, 32'h0);
		ext_run <= 1'b1;
		wait_pulse(3000, n);
		wait_pulse(3000, n);
		chk(32'(n), 32'(per_ext_1 * 4));
		$display("external source done");
	endtask
	task automatic t_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk({30'h0, req, irq}, 32'h0);
		rd(addr_pending, 32'h0);
		rd(addr_tmr_ctl, 32'h0);
		$display("reset done");
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_route();
		t_internal();
		t_stop();
		t_external();
		t_reset();
		close_out();
	end
endmodule
